/* File: verilog/jtpi_consts.vh */
// Constants for the test-access-port pin block.
// Included by the design file, the checker and the bench.
`ifndef JTPI_CONSTS_VH
`define JTPI_CONSTS_VH
`define JTPI_ST_RESET   4'h0
`define JTPI_ST_IDLE    4'h1
`define JTPI_ST_SELDR   4'h2
`define JTPI_ST_CAPDR   4'h3
`define JTPI_ST_SHDR    4'h4
`define JTPI_ST_EX1DR   4'h5
`define JTPI_ST_PAUSEDR 4'h6
`define JTPI_ST_EX2DR   4'h7
`define JTPI_ST_UPDDR   4'h8
`define JTPI_ST_SELIR   4'h9
`define JTPI_ST_CAPIR   4'ha
`define JTPI_ST_SHIR    4'hb
`define JTPI_ST_EX1IR   4'hc
`define JTPI_ST_PAUSEIR 4'hd
`define JTPI_ST_EX2IR   4'he
`define JTPI_ST_UPDIR   4'hf
`define JTPI_IR_WIDTH   4
`define JTPI_DR_WIDTH   8
`define JTPI_IR_CAPTURE 4'h1
`define JTPI_IR_BYPASS  4'hf
`define JTPI_IR_DATA    4'h2
`endif

/* File: verilog/jtpi_tap.v */
// Test-access-port pin logic: TAP state machine, instruction and data
// registers, serial output with enable, plus a two-entry output buffer
// that carries words updated under the data instruction, unless full, to core-side logic.
// Assumes the test clock is a slow pin sampled by ref_clk (>= 4x faster).
`include "jtpi_consts.vh"
module jtpi_tap #(
  parameter IRW = `JTPI_IR_WIDTH,
  parameter DRW = `JTPI_DR_WIDTH
) (
  // Clock and reset
  input  wire           ref_clk,
  input  wire           rstn,
  // Test port pins; each pin's Drv input is low when the pin floats
  input  wire           tck,
  input  wire           tckDrv,
  input  wire           tms,
  input  wire           tmsDrv,
  input  wire           tdi,
  input  wire           tdiDrv,
  output reg            tdoOut,
  output reg            tdoOe,
  // Core-side stream of updated data words
  output reg  [DRW-1:0] coreData,
  output reg            coreValid,
  input  wire           coreReady,
  // Current controller state and instruction
  output reg  [3:0]     tapState,
  output reg  [IRW-1:0] curInstr
);
  reg           rstSync1_q;
  reg           rstSync2_q;
  wire          rstnInt = rstSync2_q;
  reg  [2:0]    tckSync_q;
  reg  [2:0]    tmsSync_q;
  reg  [2:0]    tdiSync_q;
  reg           tckLvl_q;
  reg           tmsLvl_q;
  reg           tdiLvl_q;
  reg  [IRW-1:0] irShift_q;
  reg  [DRW-1:0] drShift_q;
  reg           bypass_q;
  reg  [DRW-1:0] buf0_q;
  reg  [DRW-1:0] buf1_q;
  reg  [1:0]    bufCnt_q;
  reg  [DRW-1:0] buf0_d;
  reg  [DRW-1:0] buf1_d;
  reg  [1:0]    bufCnt_d;
  reg  [3:0]    nxt;
  wire          tckRise;
  wire          tckFall;
  wire          push;
  wire          pop;
  wire          bufFull;
  wire          isBypass;

  wire tckPin = tckDrv ? tck : 1'b0;
  wire tmsPin = tmsDrv ? tms : 1'b1;
  wire tdiPin = tdiDrv ? tdi : 1'b1;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // Three-stage sampling; a level counts once stages two and three agree.
  always @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tckSync_q <= 3'h0;
      tmsSync_q <= 3'h7;
      tdiSync_q <= 3'h7;
      tckLvl_q  <= 1'b0;
      tmsLvl_q  <= 1'b1;
      tdiLvl_q  <= 1'b1;
    end else begin
      tckSync_q <= {tckSync_q[1:0], tckPin};
      tmsSync_q <= {tmsSync_q[1:0], tmsPin};
      tdiSync_q <= {tdiSync_q[1:0], tdiPin};
      if (tckSync_q[1] == tckSync_q[2]) begin
        tckLvl_q <= tckSync_q[2];
      end
      if (tmsSync_q[1] == tmsSync_q[2]) begin
        tmsLvl_q <= tmsSync_q[2];
      end
      if (tdiSync_q[1] == tdiSync_q[2]) begin
        tdiLvl_q <= tdiSync_q[2];
      end
    end
  end

  assign tckRise  = (tckSync_q[1] == tckSync_q[2]) && tckSync_q[2] && !tckLvl_q;
  assign tckFall  = (tckSync_q[1] == tckSync_q[2]) && !tckSync_q[2] && tckLvl_q;
  assign isBypass = (curInstr == `JTPI_IR_BYPASS);
  assign bufFull  = (bufCnt_q == 2'h2);
  // Updates arriving while the buffer is full are dropped; the host runs
  // far slower than the core, so this only happens if the core stalls long.
  assign push     = tckRise && (tapState == `JTPI_ST_UPDDR) &&
                    (curInstr == `JTPI_IR_DATA) && !bufFull;
  assign pop      = coreValid && coreReady;

  always @* begin
    nxt = `JTPI_ST_RESET;
    case (tapState)
      `JTPI_ST_RESET:   nxt = tmsLvl_q ? `JTPI_ST_RESET : `JTPI_ST_IDLE;
      `JTPI_ST_IDLE:    nxt = tmsLvl_q ? `JTPI_ST_SELDR : `JTPI_ST_IDLE;
      `JTPI_ST_SELDR:   nxt = tmsLvl_q ? `JTPI_ST_SELIR : `JTPI_ST_CAPDR;
      `JTPI_ST_CAPDR:   nxt = tmsLvl_q ? `JTPI_ST_EX1DR : `JTPI_ST_SHDR;
      `JTPI_ST_SHDR:    nxt = tmsLvl_q ? `JTPI_ST_EX1DR : `JTPI_ST_SHDR;
      `JTPI_ST_EX1DR:   nxt = tmsLvl_q ? `JTPI_ST_UPDDR : `JTPI_ST_PAUSEDR;
      `JTPI_ST_PAUSEDR: nxt = tmsLvl_q ? `JTPI_ST_EX2DR : `JTPI_ST_PAUSEDR;
      `JTPI_ST_EX2DR:   nxt = tmsLvl_q ? `JTPI_ST_UPDDR : `JTPI_ST_SHDR;
      `JTPI_ST_UPDDR:   nxt = tmsLvl_q ? `JTPI_ST_SELDR : `JTPI_ST_IDLE;
      `JTPI_ST_SELIR:   nxt = tmsLvl_q ? `JTPI_ST_RESET : `JTPI_ST_CAPIR;
      `JTPI_ST_CAPIR:   nxt = tmsLvl_q ? `JTPI_ST_EX1IR : `JTPI_ST_SHIR;
      `JTPI_ST_SHIR:    nxt = tmsLvl_q ? `JTPI_ST_EX1IR : `JTPI_ST_SHIR;
      `JTPI_ST_EX1IR:   nxt = tmsLvl_q ? `JTPI_ST_UPDIR : `JTPI_ST_PAUSEIR;
      `JTPI_ST_PAUSEIR: nxt = tmsLvl_q ? `JTPI_ST_EX2IR : `JTPI_ST_PAUSEIR;
      `JTPI_ST_EX2IR:   nxt = tmsLvl_q ? `JTPI_ST_UPDIR : `JTPI_ST_SHIR;
      `JTPI_ST_UPDIR:   nxt = tmsLvl_q ? `JTPI_ST_SELDR : `JTPI_ST_IDLE;
      default:          nxt = `JTPI_ST_RESET;
    endcase
  end

  always @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tapState  <= `JTPI_ST_RESET;
      curInstr  <= `JTPI_IR_BYPASS;
      irShift_q <= {IRW{1'b0}};
      drShift_q <= {DRW{1'b0}};
      bypass_q  <= 1'b0;
      tdoOut    <= 1'b0;
      tdoOe     <= 1'b0;
    end else begin
      if (tckRise) begin
        tapState <= nxt;
        case (tapState)
          `JTPI_ST_CAPIR: begin
            irShift_q <= `JTPI_IR_CAPTURE;
          end
          `JTPI_ST_CAPDR: begin
            bypass_q <= 1'b0;
          end
          `JTPI_ST_SHIR: begin
            irShift_q <= {tdiLvl_q, irShift_q[IRW-1:1]};
          end
          `JTPI_ST_SHDR: begin
            if (isBypass) begin
              bypass_q <= tdiLvl_q;
            end else begin
              drShift_q <= {tdiLvl_q, drShift_q[DRW-1:1]};
            end
          end
          `JTPI_ST_UPDIR: begin
            curInstr <= irShift_q;
          end
          default: begin
          end
        endcase
        // Bypass is selected on entry to reset, not one tck later.
        if (nxt == `JTPI_ST_RESET) begin
          curInstr <= `JTPI_IR_BYPASS;
        end
      end
      if (tckFall) begin
        if (tapState == `JTPI_ST_SHIR) begin
          tdoOut <= irShift_q[0];
          tdoOe  <= 1'b1;
        end else if (tapState == `JTPI_ST_SHDR) begin
          tdoOut <= isBypass ? bypass_q : drShift_q[0];
          tdoOe  <= 1'b1;
        end else begin
          tdoOut <= 1'b0;
          tdoOe  <= 1'b0;
        end
      end
    end
  end

  // Two-entry buffer between update and the core.
  always @* begin
    buf0_d   = buf0_q;
    buf1_d   = buf1_q;
    bufCnt_d = bufCnt_q;
    case ({push, pop})
      2'b10: begin
        if (bufCnt_q == 2'h0) begin
          buf0_d = drShift_q;
        end else begin
          buf1_d = drShift_q;
        end
        bufCnt_d = bufCnt_q + 2'h1;
      end
      2'b01: begin
        buf0_d   = buf1_q;
        bufCnt_d = bufCnt_q - 2'h1;
      end
      2'b11: begin
        if (bufCnt_q == 2'h1) begin
          buf0_d = drShift_q;
        end else begin
          buf0_d = buf1_q;
          buf1_d = drShift_q;
        end
      end
      default: begin
      end
    endcase
  end

  // The head entry is copied into the output flops from the same next
  // value, so coreValid always agrees with the count and pop stays exact.
  always @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      buf0_q    <= {DRW{1'b0}};
      buf1_q    <= {DRW{1'b0}};
      bufCnt_q  <= 2'h0;
      coreData  <= {DRW{1'b0}};
      coreValid <= 1'b0;
    end else begin
      buf0_q    <= buf0_d;
      buf1_q    <= buf1_d;
      bufCnt_q  <= bufCnt_d;
      coreData  <= buf0_d;
      coreValid <= (bufCnt_d != 2'h0);
    end
  end
endmodule

/* File: test/jtpi_tap_assertions.sv */
// Checker for the test-access-port pin block, bound to jtpi_tap.
// Assumes tck periods of eight ref_clk cycles, four high and four low.
`include "jtpi_consts.vh"
module jtpi_tap_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Test port
  input wire logic       tck,
  input wire logic       tckDrv,
  input wire logic       tdoOut,
  input wire logic       tdoOe,
  input wire logic [3:0] tapState,
  input wire logic [3:0] curInstr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // The synchroniser delays every pin edge by four cycles.
  sequence riseSeen;
    $past(tck && tckDrv, 4) && !$past(tck && tckDrv, 8);
  endsequence
  sequence fallSeen;
    !$past(tck && tckDrv, 4) && $past(tck && tckDrv, 8);
  endsequence
  a_state_on_rise: assert property ($changed(tapState) |-> riseSeen)
    else $error("state moved without a tck rise");
  a_tdo_on_fall: assert property ($changed({tdoOut, tdoOe}) |-> fallSeen)
    else $error("tdo moved without a tck fall");
  a_oe_when_shift: assert property (tdoOe |-> tapState inside
    {`JTPI_ST_SHDR, `JTPI_ST_SHIR, `JTPI_ST_EX1DR, `JTPI_ST_EX1IR})
    else $error("tdo driven outside shifting");
  a_shift_drives: assert property (tapState inside
    {`JTPI_ST_SHDR, `JTPI_ST_SHIR} && $past(tapState, 12) == tapState
    |-> tdoOe) else $error("tdo released while shifting");
  a_reset_exit: assert property ($changed(tapState) &&
    $past(tapState) == `JTPI_ST_RESET |-> tapState == `JTPI_ST_IDLE)
    else $error("bad exit from reset state");
  a_shift_entry: assert property ($changed(tapState) &&
    tapState == `JTPI_ST_SHIR |->
    $past(tapState) inside {`JTPI_ST_CAPIR, `JTPI_ST_EX2IR})
    else $error("bad entry to instruction shift");
  a_instr_update: assert property ($changed(curInstr) |->
    tapState inside {`JTPI_ST_UPDIR, `JTPI_ST_RESET} ||
    $past(tapState) inside {`JTPI_ST_UPDIR, `JTPI_ST_RESET})
    else $error("instruction changed outside update");
endmodule
bind jtpi_tap jtpi_tap_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .tck(tck), .tckDrv(tckDrv), .tdoOut(tdoOut), .tdoOe(tdoOe),
  .tapState(tapState), .curInstr(curInstr));

/* File: test/jtpi_host.sv */
// Host model of the test port: paces tck, drives tms and tdi, reads tdo.
// Assumes a 25 MHz ref_clk and calls that start at a ref_clk rise.
module jtpi_host (
  // Clock
  input  wire logic ref_clk,
  // Test port pins
  input  wire logic tdoOut,
  input  wire logic tdoOe,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic o,
                      output logic e);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    o = tdoOut;
    e = tdoOe;
    tck <= 1'b0;
  endtask
endmodule

/* File: test/jtpi_tap_bench.sv */
// Self-checking bench for the test-access-port pin block.
// Assumes the host model paces tck at 320 ns and the checker is bound.
`include "jtpi_consts.vh"
module jtpi_tap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0, rstn = 1'b0, coreReady = 1'b0;
  logic       tckDrv = 1'b1, tmsDrv = 1'b1, tdiDrv = 1'b1;
  wire        tck, tms, tdi, tdoOut, tdoOe, coreValid;
  wire  [7:0] coreData;
  wire  [3:0] tapState, curInstr;
  logic [7:0] o, e;
  int         errors = 0, compares = 0;
  jtpi_host u_host (.ref_clk(ref_clk), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .tck(tck), .tms(tms), .tdi(tdi));
  jtpi_tap uut (.ref_clk(ref_clk), .rstn(rstn), .tck(tck),
    .tckDrv(tckDrv), .tms(tms), .tmsDrv(tmsDrv), .tdi(tdi),
    .tdiDrv(tdiDrv), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .coreData(coreData), .coreValid(coreValid), .coreReady(coreReady),
    .tapState(tapState), .curInstr(curInstr));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic scan(input int n, input logic [7:0] m, d);
    for (int i = 0; i < n; i++) u_host.step(m[i], d[i], o[i], e[i]);
    // The last rise lands on the edge where step returns; let it settle.
    @(posedge ref_clk);
  endtask
  task automatic tIr(input logic [3:0] code);
    scan(4, 8'h03, 8'h00);
    scan(7, 8'h18, {4'h0, code});
    check(o & 8'h0f, 8'h01);
    check(e & 8'h7f, 8'h0f);
    check({4'h0, curInstr}, {4'h0, code});
  endtask
  task automatic tDr(input logic [7:0] d, input logic [7:0] exp);
    scan(3, 8'h01, 8'h00);
    scan(8, 8'h80, d);
    check(o, exp);
    scan(2, 8'h01, 8'h00);
    check({4'h0, tapState}, `JTPI_ST_IDLE);
  endtask
  task automatic tFloat;
    tmsDrv <= 1'b0;
    scan(3, 8'h00, 8'h00);
    check({4'h0, tapState}, `JTPI_ST_RESET);
    tmsDrv <= 1'b1;
    tckDrv <= 1'b0;
    scan(2, 8'h00, 8'h00);
    check({4'h0, tapState}, `JTPI_ST_RESET);
    tckDrv <= 1'b1;
    scan(2, 8'h00, 8'h00);
    check({4'h0, tapState}, `JTPI_ST_IDLE);
  endtask
  task automatic tBypass;
    tIr(`JTPI_IR_BYPASS);
    tDr(8'hb4, 8'h68);
    tdiDrv <= 1'b0;
    tDr(8'h00, 8'hfe);
    tdiDrv <= 1'b1;
  endtask
  task automatic tData;
    tIr(`JTPI_IR_DATA);
    tDr(8'h5a, 8'h00);
    tDr(8'h3c, 8'h5a);
    check(coreData, 8'h5a);
    check({7'h0, coreValid}, 8'h01);
    coreReady <= 1'b1;
    @(posedge ref_clk);
    coreReady <= 1'b0;
    @(posedge ref_clk);
    check(coreData, 8'h3c);
    check({7'h0, coreValid}, 8'h01);
    coreReady <= 1'b1;
    @(posedge ref_clk);
    coreReady <= 1'b0;
    @(posedge ref_clk);
    check({7'h0, coreValid}, 8'h00);
  endtask
  task automatic tTmsReset;
    tIr(`JTPI_IR_DATA);
    coreReady <= 1'b1;
    scan(5, 8'h1f, 8'h00);
    check({4'h0, tapState}, `JTPI_ST_RESET);
    check({4'h0, curInstr}, {4'h0, `JTPI_IR_BYPASS});
  endtask
  task automatic conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check({4'h0, tapState}, `JTPI_ST_RESET);
    check({7'h0, tdoOe}, 8'h00);
    tFloat();
    tBypass();
    tData();
    tTmsReset();
    conclude();
  end
endmodule
